// ==== loopback_monitor.sv ====
// Checker on the ports of the packet test-mode loopback block.
// Assumes it is bound to packet_test_loopback; one clock domain.
`timescale 1ns/1ps
module loopback_monitor
	import loopback_pkg::*;
(
	input wire logic ref_clk,        // Clock.
	input wire logic rst_n,          // Reset, low.
	input wire logic msg_valid,      // Message strobe.
	input wire msg_s msg,            // Message fields.
	input wire logic ul_flow_active, // Uplink flow.
	input wire logic dl_ctrl_valid,  // Control block in.
	input wire logic ul_req,         // Uplink slot due.
	input wire logic poll_req,       // Slot polled.
	input wire logic audio_test_on,  // Audio test port on.
	input wire logic maint_rx_ready, // Ready for frames.
	input wire logic flow_req,       // Flow request.
	input wire logic test_mode,      // Test mode.
	input wire logic ul_valid,       // Uplink block.
	input wire logic ul_ctrl,        // Control block out.
	input wire logic ctrl_resp,      // Control answer.
	input wire logic maint_active,   // Maintenance on.
	input wire logic maint_ack,      // Activation ack.
	input wire logic maint_resume,   // Resume message.
	input wire logic [2:0] audio_func // Audio function.
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	wire logic acc = msg_valid && msg.skip == 4'h0;

	AST_FLOW_CAUSE: assert property (flow_req |-> $past(acc && msg.kind == MSG_TEST_MODE))
		else $error("flow request without a command");
	AST_SKIP: assert property (msg_valid && msg.skip != 4'h0 |=> !flow_req && !maint_ack)
		else $error("skipped message acted on");
	AST_ACK: assert property (acc && msg.kind == MSG_MAINT_ACT |=> maint_ack)
		else $error("activation not acknowledged");
	AST_CTRL: assert property (dl_ctrl_valid |=> ctrl_resp)
		else $error("control block not answered");
	AST_POLL: assert property (ul_req && poll_req |=> ul_valid && ul_ctrl)
		else $error("poll not answered with control block");
	AST_END: assert property (!ul_flow_active [*3] |-> !test_mode)
		else $error("test mode outlives uplink flow");
	AST_DEACT: assert property (acc && msg.kind == MSG_MAINT_DEACT |=> !maint_active [*2])
		else $error("maintenance still on after deactivation");
	AST_RESUME: assert property ($rose(maint_active) && maint_rx_ready |-> ##[1:2] maint_resume)
		else $error("resume not sent on activation");
	AST_RESUME_ONCE: assert property (maint_resume |=> !maint_resume)
		else $error("resume sent twice");
	AST_AUDIO: assert property (acc && msg.kind == MSG_AUDIO_TEST && audio_test_on
		|=> audio_func == $past(msg.audio_func))
		else $error("audio function not replaced");
endmodule // loopback_monitor

bind packet_test_loopback loopback_monitor mon (.ref_clk, .rst_n, .msg_valid, .msg,
	.ul_flow_active, .dl_ctrl_valid, .ul_req, .poll_req, .audio_test_on, .maint_rx_ready,
	.flow_req, .test_mode, .ul_valid, .ul_ctrl, .ctrl_resp, .maint_active, .maint_ack,
	.maint_resume, .audio_func);

// ==== loopback_params.svh ====
// Constants of the packet test-mode loopback block.
// Assumes one 100 MHz clock and an outside framer giving block and slot events.
`ifndef LOOPBACK_PARAMS_SVH
`define LOOPBACK_PARAMS_SVH
`define PAYLOAD_W     32
`define NUM_TS        8
`define RTD_BLOCKS    2'h2
`define RTD_MIN       1
`define RTD_MAX_EXCL  6
`define BANKS         4
`define PN_SEED       15'h7fff
`define SKIP_NONE     4'h0
`endif

// ==== loopback_pkg.sv ====
// Types shared by the packet test-mode loopback block.
// Assumes the message decoder upstream fills msg_s from the air message.
package loopback_pkg;
	typedef enum logic [2:0] {
		MSG_NONE        = 3'b000,
		MSG_TEST_MODE   = 3'b001,
		MSG_MAINT_ACT   = 3'b010,
		MSG_MAINT_DEACT = 3'b011,
		MSG_AUDIO_TEST  = 3'b100
	} msg_kind_e;

	typedef enum logic [1:0] {
		TM_IDLE    = 2'b00,
		TM_REQUEST = 2'b01,
		TM_ACTIVE  = 2'b10
	} tm_state_e;

	typedef struct packed {
		logic [3:0] skip;
		msg_kind_e  kind;
		logic [2:0] dl_offset;
		logic [1:0] radio_prio;
		logic [3:0] thr_class;
		logic       loop_mode;
		logic       multislot;
		logic [2:0] audio_func;
	} msg_s;

	typedef struct packed {
		logic [2:0]  tn;
		logic [31:0] payload;
	} dl_block_s;
endpackage

// ==== packet_test_loopback.sv ====
// Mobile-side logic of the packet test mode, maintenance interface and audio test.
// Assumes decoded messages, slot masks and block ticks come from the modem core.
`timescale 1ns/1ps
`include "loopback_params.svh"

module packet_test_loopback
	import loopback_pkg::*;
(
	input  wire logic                  ref_clk,          // System clock.
	input  wire logic                  rst_n,            // Async reset, low.
	input  wire logic                  msg_valid,        // Decoded message strobe.
	input  wire msg_s                  msg,              // Decoded message fields.
	input  wire logic                  ul_flow_active,   // Uplink flow exists.
	input  wire logic                  dl_flow_active,   // Downlink flow exists.
	input  wire logic                  contention_done,  // Contention resolved.
	input  wire logic [7:0]            dl_ts_mask,       // Active downlink slots.
	input  wire logic [7:0]            ul_ts_mask,       // Active uplink slots.
	input  wire logic                  block_tick,       // Radio block boundary.
	input  wire logic                  dl_valid,         // Downlink data block.
	input  wire dl_block_s             dl_blk,           // Slot and payload.
	input  wire logic                  dl_ctrl_valid,    // Downlink control block.
	input  wire logic                  ul_req,           // Uplink slot due.
	input  wire logic [2:0]            ul_tn,            // Uplink slot number.
	input  wire logic                  poll_req,         // Slot was polled.
	input  wire logic                  test_sim_present, // Test card inserted.
	input  wire logic                  maint_rx_ready,   // Ready for frames.
	input  wire logic                  audio_test_on,    // Speech from test port.
	output logic                       flow_req,         // Request uplink flow.
	output logic                       realloc_req,      // Request reallocation.
	output logic                       test_mode,        // Test mode in force.
	output logic                       ul_valid,         // Uplink block ready.
	output logic                       ul_ctrl,          // Block is control.
	output logic [`PAYLOAD_W-1:0]      ul_payload,       // Uplink payload.
	output logic                       ctrl_resp,        // Answer control block.
	output logic                       maint_active,     // Maintenance on.
	output logic                       maint_ack,        // Activation ack.
	output logic                       maint_resume,     // Flow-control resume.
	output logic [2:0]                 audio_func        // Audio test function.
);

	tm_state_e                 state_r;
	tm_state_e                 state_nxt;
	logic [1:0]                prio_r;
	logic [3:0]                class_r;
	logic [2:0]                offset_r;
	logic                      loop_r;
	logic                      multi_r;
	logic [14:0]               pn_r;
	logic [1:0]                wr_bank_r;
	logic [`BANKS*`NUM_TS-1:0] held_r;
	logic [`PAYLOAD_W-1:0]     mem [0:`BANKS*`NUM_TS-1];
	logic                      sim_d_r;
	logic                      resumed_r;
	logic                      msg_ok;
	logic                      cmd_test;
	logic                      needs_realloc;
	logic [1:0]                rd_bank;
	logic [2:0]                dl_rank_w;
	logic [2:0]                ul_rank_w;
	logic [3:0]                dl_count;
	logic [2:0]                src_rank;
	logic [4:0]                rd_idx;
	logic                      use_loop;
	logic [46:0]               pn_next;

	// Advances the x^15+x^14+1 generator by one payload word.
	function automatic logic [46:0] pn_step(input logic [14:0] s);
		logic [14:0]           t;
		logic [`PAYLOAD_W-1:0] w;
		t = s;
		w = '0;
		for (int i = 0; i < `PAYLOAD_W; i++) begin
			w = {w[`PAYLOAD_W-2:0], t[14]};
			t = {t[13:0], t[14] ^ t[13]};
		end
		return {t, w};
	endfunction

	// Position of a downlink slot counted from the offset, inactive slots skipped.
	function automatic logic [2:0] dl_rank(input logic [7:0] m, input logic [2:0] off,
		input logic [2:0] tn);
		logic [2:0] r;
		logic [2:0] s;
		logic       hit;
		r = '0;
		hit = 1'b0;
		for (int i = 0; i < `NUM_TS; i++) begin
			s = off + i[2:0];
			if (s == tn) begin
				hit = 1'b1;
			end else if (!hit && m[s]) begin
				r = r + 3'h1;
			end
		end
		return r;
	endfunction

	// Position of an uplink slot counted from slot zero.
	function automatic logic [2:0] ul_rank(input logic [7:0] m, input logic [2:0] tn);
		logic [2:0] r;
		r = '0;
		for (int i = 0; i < `NUM_TS; i++) begin
			if (i[2:0] < tn && m[i]) begin
				r = r + 3'h1;
			end
		end
		return r;
	endfunction

	function automatic logic [3:0] pop8(input logic [7:0] m);
		logic [3:0] c;
		c = '0;
		for (int i = 0; i < `NUM_TS; i++) begin
			c = c + {3'h0, m[i]};
		end
		return c;
	endfunction

	assign msg_ok = msg_valid && (msg.skip == `SKIP_NONE);
	assign cmd_test = msg_ok && (msg.kind == MSG_TEST_MODE);
	assign needs_realloc = (msg.radio_prio != prio_r) || (msg.thr_class != class_r);

	// Test-mode sequencing.
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			TM_IDLE: begin
				if (cmd_test) begin
					state_nxt = ul_flow_active ? TM_ACTIVE : TM_REQUEST;
				end
			end
			TM_REQUEST: begin
				if (ul_flow_active) begin
					state_nxt = TM_ACTIVE;
				end
			end
			TM_ACTIVE: begin
				if (!ul_flow_active) begin
					state_nxt = TM_IDLE;
				end
			end
			default: begin
				state_nxt = TM_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= TM_IDLE;
			test_mode <= 1'b0;
		end else begin
			state_r <= state_nxt;
			test_mode <= (state_nxt == TM_ACTIVE);
		end
	end

	// Flow requests and the commanded parameters.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flow_req <= 1'b0;
			realloc_req <= 1'b0;
			prio_r <= '0;
			class_r <= '0;
			offset_r <= '0;
			loop_r <= 1'b0;
			multi_r <= 1'b0;
		end else begin
			flow_req <= cmd_test && !ul_flow_active;
			realloc_req <= cmd_test && ul_flow_active && needs_realloc;
			if (cmd_test) begin
				prio_r <= msg.radio_prio;
				class_r <= msg.thr_class;
				offset_r <= msg.dl_offset;
				loop_r <= msg.loop_mode;
				multi_r <= msg.multislot;
			end
		end
	end

	// Downlink payloads are banked per radio block and per slot position.
	assign dl_rank_w = dl_rank(dl_ts_mask, offset_r, dl_blk.tn);
	assign rd_bank = wr_bank_r - `RTD_BLOCKS;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_bank_r <= '0;
		end else if (block_tick) begin
			wr_bank_r <= wr_bank_r + 2'h1;
		end
	end

	generate
		for (genvar g = 0; g < `BANKS*`NUM_TS; g++) begin : g_held
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					held_r[g] <= 1'b0;
				end else if (dl_valid && {wr_bank_r, dl_rank_w} == 5'(g)) begin
					held_r[g] <= 1'b1;
				end else if (block_tick && 2'(wr_bank_r + 2'h1) == 2'(g / `NUM_TS)) begin
					held_r[g] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (dl_valid) begin
			mem[{wr_bank_r, dl_rank_w}] <= dl_blk.payload;
		end
	end

	// Choice of the source slot for an uplink block.
	assign ul_rank_w = ul_rank(ul_ts_mask, ul_tn);
	assign dl_count = pop8(dl_ts_mask);

	always_comb begin
		if (!multi_r || dl_count <= 4'h1) begin
			src_rank = 3'h0;
		end else if ({1'b0, ul_rank_w} >= dl_count) begin
			src_rank = dl_count[2:0] - 3'h1;
		end else begin
			src_rank = ul_rank_w;
		end
	end

	assign rd_idx = {rd_bank, src_rank};
	assign use_loop = loop_r && dl_flow_active && contention_done && held_r[rd_idx];
	assign pn_next = pn_step(pn_r);

	// Uplink block assembly; polled slots carry control blocks.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ul_valid <= 1'b0;
			ul_ctrl <= 1'b0;
			ul_payload <= '0;
			pn_r <= `PN_SEED;
		end else begin
			ul_valid <= ul_req && (test_mode || poll_req);
			ul_ctrl <= ul_req && poll_req;
			if (ul_req && poll_req) begin
				ul_payload <= '0;
			end else if (ul_req && test_mode && use_loop) begin
				ul_payload <= mem[rd_idx];
			end else if (ul_req && test_mode) begin
				ul_payload <= pn_next[`PAYLOAD_W-1:0];
				pn_r <= pn_next[46:32];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_resp <= 1'b0;
		end else begin
			ctrl_resp <= dl_ctrl_valid;
		end
	end

	// Maintenance interface activation and its one-time resume.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			sim_d_r <= 1'b0;
			maint_active <= 1'b0;
			maint_ack <= 1'b0;
			maint_resume <= 1'b0;
			resumed_r <= 1'b0;
		end else begin
			sim_d_r <= test_sim_present;
			maint_ack <= msg_ok && msg.kind == MSG_MAINT_ACT;
			maint_resume <= 1'b0;
			if (!test_sim_present || (msg_ok && msg.kind == MSG_MAINT_DEACT)) begin
				maint_active <= 1'b0;
				resumed_r <= 1'b0;
			end else if ((test_sim_present && !sim_d_r) ||
				(msg_ok && msg.kind == MSG_MAINT_ACT)) begin
				maint_active <= 1'b1;
			end else if (maint_active && maint_rx_ready && !resumed_r) begin
				maint_resume <= 1'b1;
				resumed_r <= 1'b1;
			end
		end
	end

	// Audio test function: while audio_test_on is high, each new command replaces the one in force.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			audio_func <= '0;
		end else if (msg_ok && msg.kind == MSG_AUDIO_TEST && audio_test_on) begin
			audio_func <= msg.audio_func;
		end
	end

endmodule // packet_test_loopback

// ==== sim_partner.sv ====
// Simulator side of the uplink flow: grants a requested flow, releases on demand.
// Assumes flow_req is a one-cycle pulse from the loopback block.
`timescale 1ns/1ps
module sim_partner (
	input  wire logic       ref_clk,       // Clock.
	input  wire logic       rst_n,         // Reset, low.
	input  wire logic       flow_req,      // Channel request seen.
	input  wire logic       release_req,   // Release the flow.
	input  wire logic [3:0] grant_delay,   // Cycles to grant.
	output logic            ul_flow_active // Flow established.
);
	logic [3:0] wait_r;
	logic       pend_r;
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ul_flow_active <= 1'b0;
			pend_r <= 1'b0;
			wait_r <= 4'h0;
		end else if (release_req) begin
			ul_flow_active <= 1'b0;
			pend_r <= 1'b0;
		end else if (flow_req) begin
			pend_r <= 1'b1;
			wait_r <= grant_delay;
		end else if (pend_r && wait_r == 4'h0) begin
			ul_flow_active <= 1'b1;
			pend_r <= 1'b0;
		end else if (pend_r) begin
			wait_r <= wait_r - 4'h1;
		end
	end
endmodule // sim_partner

// ==== tb.sv ====
// Self-checking bench of the packet test-mode loopback block.
// Assumes sim_partner grants the uplink flow; payloads are random.
`timescale 1ns/1ps
module tb;
	import loopback_pkg::*;
	logic ref_clk = 0, rst_n = 0, msg_valid = 0, dl_flow_active = 1, contention_done = 1;
	logic block_tick = 0, dl_valid = 0, dl_ctrl_valid = 0, ul_req = 0, poll_req = 0;
	logic test_sim_present = 0, maint_rx_ready = 0, audio_test_on = 0, release_req = 0;
	logic [7:0] dl_ts_mask = 8'h01, ul_ts_mask = 8'h01;
	logic [2:0] ul_tn = 3'h0, audio_func;
	logic [3:0] grant_delay = 4'h0;
	msg_s msg = '0;
	dl_block_s dl_blk = '0;
	logic ul_flow_active, flow_req, realloc_req, test_mode, ul_valid, ul_ctrl;
	logic ctrl_resp, maint_active, maint_ack, maint_resume;
	logic [31:0] ul_payload, p0, p1;
	int mismatches = 0, n_checks = 0, k;

	always #5 ref_clk = ~ref_clk;

	packet_test_loopback dut (.ref_clk, .rst_n, .msg_valid, .msg, .ul_flow_active,
		.dl_flow_active, .contention_done, .dl_ts_mask, .ul_ts_mask, .block_tick, .dl_valid,
		.dl_blk, .dl_ctrl_valid, .ul_req, .ul_tn, .poll_req, .test_sim_present,
		.maint_rx_ready, .audio_test_on, .flow_req, .realloc_req, .test_mode, .ul_valid,
		.ul_ctrl, .ul_payload, .ctrl_resp, .maint_active, .maint_ack, .maint_resume,
		.audio_func);
	sim_partner sim (.ref_clk, .rst_n, .flow_req, .release_req, .grant_delay,
		.ul_flow_active);

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// First PN15 words from the reset seed, x^15+x^14+1, MSB first.
	function automatic logic [31:0] pn_ref(input int n);
		logic [14:0] s;
		logic [31:0] w;
		s = 15'h7fff;
		w = '0;
		repeat (n) for (int i = 0; i < 32; i++) begin
			w = {w[30:0], s[14]};
			s = {s[13:0], s[14] ^ s[13]};
		end
		return w;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask
	// The 3-bit value p feeds both the priority and the audio function fields.
	task automatic send(input msg_kind_e kd, input logic [3:0] sk, input logic [2:0] off,
		input logic [2:0] p, input logic lm, input logic ms);
		@(posedge ref_clk);
		msg_valid <= 1;
		msg <= {sk, kd, off, p[1:0], 4'h0, lm, ms, p};
		@(posedge ref_clk);
		msg_valid <= 0;
		#1;
	endtask
	task automatic dl(input logic [2:0] tn, input logic [31:0] pl);
		@(posedge ref_clk);
		dl_valid <= 1;
		dl_blk <= {tn, pl};
		@(posedge ref_clk);
		dl_valid <= 0;
	endtask
	task automatic ticks;
		repeat (2) begin
			@(posedge ref_clk);
			block_tick <= 1;
			@(posedge ref_clk);
			block_tick <= 0;
		end
	endtask
	task automatic ul(input logic [2:0] tn, input logic pl);
		@(posedge ref_clk);
		ul_req <= 1;
		ul_tn <= tn;
		poll_req <= pl;
		@(posedge ref_clk);
		ul_req <= 0;
		poll_req <= 0;
		#1;
	endtask
	task automatic count_pulses;
		k = 0;
		repeat (10) begin
			cyc(1);
			k += maint_resume + maint_ack;
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		stop_test;
	end

	initial begin
		k = $urandom(32'hab4d);
		repeat (5) @(posedge ref_clk);
		rst_n <= 1;
		grant_delay <= 4'($urandom_range(7, 0));
		cyc(2);
		send(MSG_TEST_MODE, 4'($urandom_range(15, 1)), 3'h0, 3'h1, 1, 0);
		chk(flow_req, 0);
		send(MSG_TEST_MODE, 4'h0, 3'h0, 3'h1, 1, 0);
		chk(flow_req, 1);
		for (k = 0; k < 30 && test_mode !== 1'b1; k++) cyc(1);
		chk(test_mode, 1);
		p0 = $urandom;
		dl(3'h0, p0);
		ticks;
		ul(3'h0, 0);
		chk({ul_valid, ul_payload == p0}, 3);
		@(posedge ref_clk);
		dl_ts_mask <= 8'h30;
		ul_ts_mask <= 8'h07;
		send(MSG_TEST_MODE, 4'h0, 3'h5, 3'h2, 1, 1);
		chk(realloc_req, 1);
		p0 = $urandom;
		p1 = $urandom;
		dl(3'h4, p1);
		dl(3'h5, p0);
		ticks;
		ul(3'h0, 0);
		chk(ul_payload, p0);
		ul(3'h1, 0);
		chk(ul_payload, p1);
		ul(3'h2, 0);
		chk(ul_payload, p1);
		@(posedge ref_clk);
		dl_ts_mask <= 8'h10;
		dl(3'h4, p0);
		ticks;
		ul(3'h2, 0);
		chk(ul_payload, p0);
		send(MSG_TEST_MODE, 4'h0, 3'h5, 3'h2, 0, 0);
		ul(3'h0, 0);
		p0 = ul_payload;
		ul(3'h0, 0);
		chk({p0 != 0, p0 != ul_payload}, 3);
		chk(p0, pn_ref(1));
		chk(ul_payload, pn_ref(2));
		ul(3'h1, 1);
		chk({ul_valid, ul_ctrl, ul_payload == 0}, 7);
		@(posedge ref_clk);
		dl_ctrl_valid <= 1;
		@(posedge ref_clk);
		dl_ctrl_valid <= 0;
		#1 chk(ctrl_resp, 1);
		@(posedge ref_clk);
		maint_rx_ready <= 1;
		test_sim_present <= 1;
		count_pulses;
		chk({maint_active, 4'(k)}, 5'h11);
		send(MSG_MAINT_ACT, 4'h0, 3'h0, 3'h0, 0, 0);
		chk(maint_ack, 1);
		send(MSG_MAINT_DEACT, 4'h0, 3'h0, 3'h0, 0, 0);
		count_pulses;
		chk({maint_active, 4'(k)}, 0);
		@(posedge ref_clk);
		audio_test_on <= 1;
		p0 = $urandom;
		send(MSG_AUDIO_TEST, 4'h0, 3'h0, p0[2:0], 0, 0);
		send(MSG_AUDIO_TEST, 4'h0, 3'h0, p0[5:3], 0, 0);
		chk(audio_func, p0[5:3]);
		@(posedge ref_clk);
		release_req <= 1;
		@(posedge ref_clk);
		release_req <= 0;
		cyc(4);
		chk(test_mode, 0);
		ul(3'h0, 0);
		chk(ul_valid, 0);
		stop_test;
	end
endmodule // tb
